// [shared/strc_params.svh]
`ifndef STRC_PARAMS_SVH
`define STRC_PARAMS_SVH
// Behaviour
// - Table space is one 64-byte row of eight 8-byte tables, numbered 0 to 7.
// - Table fetch uses the low three select bits and ignores the upper five.
// - Table fetch copies eight selected bytes into parameter area F8h..FFh.
// - Table 0 leaves silicon id in SRAM, revision in A, family in X.
// - Table 1 returns the internal revision counter in A and FFh in X.
// - Tables 2 to 7 return FFh in both A and X.
// - Internal revision counter starts at zero; it is a build-time parameter.
// - Die revision is a fixed 16-bit ROM value; table 0 returns its low byte in A.
// - After table 0, silicon id high byte sits at F8h and low at F9h.
// - Table 2 holds fast oscillator trims for 3.3, 3.0, 2.85, 2.7 V at FC..FF.
// - Checksum starts at block 0; count 1 is block 0 only, 0 means 256 blocks.
// - Checksum stays inside one flash bank and never crosses into another.
// - Per byte of count times 64: read, add to low byte, carry into high byte.
// - Checksum low byte returns at F8h, high byte at F9h.
// - Parameter block is F8h..FFh: keys at F8h, F9h, selector at FAh.

`define STRC_PARAM_BASE     8'hF8
`define STRC_ADDR_SUP_KEY   8'hF8
`define STRC_ADDR_STACK_KEY 8'hF9
`define STRC_ADDR_SELECT    8'hFA
`define STRC_ADDR_TRIM0     8'hFC
`define STRC_KEY_VALUE      8'h3A
`define STRC_OP_TABLE       8'h06
`define STRC_OP_CHECKSUM    8'h07
`define STRC_BLANK_BYTE     8'hFF
`define STRC_TABLE_BYTES    4'h8
`define STRC_BLOCK_BYTES    7'h40
`define STRC_FULL_BLOCKS    9'h100
`define STRC_ROW_BASE       14'h0000
`endif

// [shared/strc_pkg.sv]
package strc_pkg;
  // Call request from the CPU side
  typedef struct packed {
    logic       start;
    logic [7:0] op;
  } strc_call_type;
  // Result handed back to the CPU registers
  typedef struct packed {
    logic       done;
    logic       key_error;
    logic [7:0] acc;
    logic [7:0] idx;
  } strc_result_type;
  // SRAM write port
  typedef struct packed {
    logic       we;
    logic [7:0] addr;
    logic [7:0] data;
  } strc_sram_wr_type;
  typedef enum logic [7:0] {
    STRC_IDLE    = 8'b00000001,
    STRC_SUPERVISORY_KEY_BYTE    = 8'b00000010,
    STRC_STACK_KEY_BYTE    = 8'b00000100,
    STRC_SELECT  = 8'b00001000,
    STRC_DISPATCH = 8'b00010000,
    STRC_TABLE   = 8'b00100000,
    STRC_SUM     = 8'b01000000,
    STRC_FINISH  = 8'b10000000
  } strc_state_type;
endpackage : strc_pkg

// [core/strc_table_rom.sv]
`timescale 1ns/1ns
`include "strc_params.svh"
// Sixty-four-byte manufacturing row lookup, combinational
module strc_table_rom #(
  parameter logic [511:0] ROW_IMAGE = {512{1'b1}}
) (
  input  wire logic [2:0] table_sel,
  input  wire logic [2:0] byte_sel,
  output logic [7:0]      data
);
  import strc_pkg::*;
  // Row is 64 bytes as eight tables of eight; byte 0 is the table's F8h slot
  always_comb begin
    data = ROW_IMAGE[{table_sel, byte_sel, 3'b000} +: 8];
  end
endmodule : strc_table_rom

// [core/strc_sum_acc.sv]
`timescale 1ns/1ns
`include "strc_params.svh"
// Sixteen-bit additive checksum accumulator
module strc_sum_acc (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        clear,
  input  wire logic        add,
  input  wire logic [7:0]  data,
  output logic [15:0]      sum
);
  import strc_pkg::*;
  logic [15:0] next_sum;
  logic [8:0]  low_add;
  // Low byte takes the data, high byte takes only the carry
  always_comb begin
    low_add  = {1'b0, sum[7:0]} + {1'b0, data};
    next_sum = sum;
    if (clear) begin
      next_sum = 16'h0000;
    end else if (add) begin
      next_sum = {sum[15:8] + {7'h00, low_add[8]}, low_add[7:0]};
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sum <= 16'h0000;
    end else begin
      sum <= next_sum;
    end
  end
endmodule : strc_sum_acc

// [core/strc_service.sv]
`timescale 1ns/1ns
`include "strc_params.svh"
// Supervisory call service: table fetch and flash checksum
module strc_service #(
  parameter logic [15:0]  DIE_REVISION   = 16'h0000, // Arbitrary value
  parameter logic [7:0]   FAMILY_ID      = 8'h00,    // Arbitrary value
  parameter logic [7:0]   INT_REV_COUNT  = 8'h00,
  parameter logic [511:0] ROW_IMAGE      = {512{1'b1}},
  parameter int           FLASH_AW       = 14
) (
  input  wire logic                      clock,
  input  wire logic                      rst_b,
  input  wire strc_pkg::strc_call_type   call,
  input  wire logic [7:0]                sram_rdata,
  input  wire logic [7:0]                flash_rdata,
  output strc_pkg::strc_result_type      result,
  output logic [7:0]                     sram_raddr,
  output strc_pkg::strc_sram_wr_type     sram_wr,
  output logic                           flash_re,
  output logic [FLASH_AW-1:0]            flash_addr,
  output logic                           busy
);
  import strc_pkg::*;

  strc_state_type     state;
  strc_state_type     next_state;
  logic [7:0]         op;
  logic [7:0]         next_op;
  logic [7:0]         select;
  logic [7:0]         next_select;
  logic [14:0]        count;
  logic [14:0]        next_count;
  logic [14:0]        total;
  logic [14:0]        next_total;
  logic               pend;
  logic               next_pend;
  logic               key_bad;
  logic               next_key_bad;
  strc_result_type    next_result;
  logic [7:0]         next_sram_raddr;
  strc_sram_wr_type   next_sram_wr;
  logic               next_flash_re;
  logic [FLASH_AW-1:0] next_flash_addr;
  logic               next_busy;
  logic [7:0]         rom_data;
  logic [15:0]        sum;
  logic               sum_clear;
  logic               sum_add;
  logic [8:0]         blocks;

  // Block count of a checksum; a zero selector means every user block
  function automatic logic [8:0] block_count(input logic [7:0] sel);
    block_count = (sel == 8'h00) ? `STRC_FULL_BLOCKS : {1'b0, sel};
  endfunction : block_count

  strc_table_rom #(
    .ROW_IMAGE (ROW_IMAGE)
  ) u_rom (
    .table_sel (select[2:0]),
    .byte_sel  (count[2:0]),
    .data      (rom_data)
  );

  strc_sum_acc u_sum (
    .clock (clock),
    .rst_b (rst_b),
    .clear (sum_clear),
    .add   (sum_add),
    .data  (flash_rdata),
    .sum   (sum)
  );

  assign blocks = block_count(select);

  // Sequencer: read the key at F8h and the selector at FAh, then run the requested service
  always_comb begin
    next_state      = state;
    next_op         = op;
    next_select     = select;
    next_count      = count;
    next_total      = total;
    next_pend       = 1'b0;
    next_key_bad    = key_bad;
    next_result     = result;
    next_result.done = 1'b0;
    next_sram_raddr = sram_raddr;
    next_sram_wr    = '0;
    next_flash_re   = 1'b0;
    next_flash_addr = flash_addr;
    next_busy       = busy;
    sum_clear       = 1'b0;
    sum_add         = 1'b0;
    case (state)
      STRC_IDLE: begin
        if (call.start) begin
          next_op         = call.op;
          next_sram_raddr = `STRC_ADDR_SUP_KEY;
          next_busy       = 1'b1;
          next_key_bad    = 1'b0;
          next_state      = STRC_SUPERVISORY_KEY_BYTE;
        end
      end
      STRC_SUPERVISORY_KEY_BYTE: begin
        // SRAM read data is valid one cycle after the address
        next_sram_raddr = `STRC_ADDR_SELECT;
        next_state      = STRC_STACK_KEY_BYTE;
      end
      STRC_STACK_KEY_BYTE: begin
        // Only the fixed key is checked; the stack key is not verifiable here
        next_key_bad = (sram_rdata != `STRC_KEY_VALUE);
        next_state   = STRC_SELECT;
      end
      STRC_SELECT: begin
        next_select = sram_rdata;
        next_state  = STRC_DISPATCH;
      end
      STRC_DISPATCH: begin
        next_count = 15'h0000;
        sum_clear  = 1'b1;
        next_total = {blocks, 6'h00};
        if (key_bad) begin
          next_result.acc = `STRC_BLANK_BYTE;
          next_result.idx = `STRC_BLANK_BYTE;
          next_state      = STRC_FINISH;
        end else if (op == `STRC_OP_TABLE) begin
          next_state = STRC_TABLE;
        end else if (op == `STRC_OP_CHECKSUM) begin
          next_flash_addr = `STRC_ROW_BASE;
          next_flash_re   = 1'b1;
          next_state      = STRC_SUM;
        end else begin
          // Unknown codes finish at once with blank returns and touch no memory
          next_result.acc = `STRC_BLANK_BYTE;
          next_result.idx = `STRC_BLANK_BYTE;
          next_state      = STRC_FINISH;
        end
      end
      STRC_TABLE: begin
        // One byte per cycle into F8h..FFh; table 0 bytes F8/F9 are id high/low
        next_sram_wr.we   = 1'b1;
        next_sram_wr.addr = `STRC_PARAM_BASE + {5'h00, count[2:0]};
        next_sram_wr.data = rom_data;
        next_count        = count + 15'h0001;
        if (count[2:0] == 3'h7) begin
          next_state = STRC_FINISH;
          case (select[2:0])
            3'h0: begin
              next_result.acc = DIE_REVISION[7:0];
              next_result.idx = FAMILY_ID;
            end
            3'h1: begin
              next_result.acc = INT_REV_COUNT;
              next_result.idx = `STRC_BLANK_BYTE;
            end
            default: begin
              next_result.acc = `STRC_BLANK_BYTE;
              next_result.idx = `STRC_BLANK_BYTE;
            end
          endcase
        end
      end
      STRC_SUM: begin
        // Reads go out on alternate cycles so each byte is added exactly once
        // Trade-off: half the read rate, but no read is ever in flight twice
        next_pend = flash_re;
        if (pend) begin
          sum_add    = 1'b1;
          next_count = count + 15'h0001;
          if (count + 15'h0001 == total) begin
            next_state = STRC_FINISH;
            next_count = 15'h0000;
          end else begin
            // Address stays inside the single bank row space
            next_flash_addr = flash_addr + {{(FLASH_AW-1){1'b0}}, 1'b1};
            next_flash_re   = 1'b1;
          end
        end
      end
      STRC_FINISH: begin
        // Checksum result takes two cycles: low byte, then high byte with done
        if (op == `STRC_OP_CHECKSUM && !key_bad && count == 15'h0000) begin
          next_sram_wr.we   = 1'b1;
          next_sram_wr.addr = `STRC_ADDR_SUP_KEY;
          next_sram_wr.data = sum[7:0];
          next_count        = 15'h0001;
        end else if (op == `STRC_OP_CHECKSUM && !key_bad) begin
          next_sram_wr.we   = 1'b1;
          next_sram_wr.addr = `STRC_ADDR_STACK_KEY;
          next_sram_wr.data = sum[15:8];
          next_count        = 15'h0000;
          next_result.done  = 1'b1;
          next_result.key_error = 1'b0;
          next_busy         = 1'b0;
          next_state        = STRC_IDLE;
        end else begin
          next_result.done      = 1'b1;
          next_result.key_error = key_bad;
          next_busy             = 1'b0;
          next_state            = STRC_IDLE;
        end
      end
      default: begin
        next_state = STRC_IDLE;
      end
    endcase
  end

  // State registers; reset leaves an idle block with every strobe low
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state      <= STRC_IDLE;
      op         <= 8'h00;
      select     <= 8'h00;
      count      <= 15'h0000;
      total      <= 15'h0000;
      pend       <= 1'b0;
      key_bad    <= 1'b0;
      result     <= '0;
      sram_raddr <= 8'h00;
      sram_wr    <= '0;
      flash_re   <= 1'b0;
      flash_addr <= '0;
      busy       <= 1'b0;
    end else begin
      state      <= next_state;
      op         <= next_op;
      select     <= next_select;
      count      <= next_count;
      total      <= next_total;
      pend       <= next_pend;
      key_bad    <= next_key_bad;
      result     <= next_result;
      sram_raddr <= next_sram_raddr;
      sram_wr    <= next_sram_wr;
      flash_re   <= next_flash_re;
      flash_addr <= next_flash_addr;
      busy       <= next_busy;
    end
  end

  // Sequencer checks; all are gated by reset
  // Table fetch writes stay inside the parameter area
  table_write_area_a: assert property (@(posedge clock) disable iff (!rst_b)
    sram_wr.we && state == STRC_TABLE |-> sram_wr.addr >= `STRC_PARAM_BASE)
    else $error("table write outside parameter area");
  // Blank tables return FFh
  blank_table_ret_a: assert property (@(posedge clock) disable iff (!rst_b)
    result.done && op == `STRC_OP_TABLE && select[2:1] != 2'b00 |-> result.acc == 8'hFF && result.idx == 8'hFF)
    else $error("tables 2 to 7 must return FFh");
  // Table one index is FFh
  table_one_idx_a: assert property (@(posedge clock) disable iff (!rst_b)
    result.done && !result.key_error && op == `STRC_OP_TABLE && select[2:0] == 3'h1 |-> result.idx == 8'hFF)
    else $error("table 1 index must be FFh");
  // Table zero returns family id
  table_zero_ret_a: assert property (@(posedge clock) disable iff (!rst_b)
    result.done && !result.key_error && op == `STRC_OP_TABLE && select[2:0] == 3'h0 |-> result.idx == FAMILY_ID)
    else $error("table 0 must return family id");
  // Sum cleared at dispatch
  sum_clear_start_a: assert property (@(posedge clock) disable iff (!rst_b)
    state == STRC_DISPATCH |=> sum == 16'h0000)
    else $error("checksum not cleared before first add");
  // Low then high result order
  sum_low_high_a: assert property (@(posedge clock) disable iff (!rst_b)
    sram_wr.we && sram_wr.addr == 8'hF8 && state == STRC_FINISH |=> sram_wr.we && sram_wr.addr == 8'hF9)
    else $error("checksum high byte must follow at F9h");
  // Eight table bytes in a row
  table_eight_bytes_a: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(state == STRC_TABLE) |-> (state == STRC_TABLE)[*8] ##1 state == STRC_FINISH)
    else $error("table fetch must take eight cycles");
  // Key check gates service
  key_guard_a: assert property (@(posedge clock) disable iff (!rst_b)
    state == STRC_DISPATCH && key_bad |=> state == STRC_FINISH)
    else $error("bad key must not run service");
  // Checksum reads start at address zero and cover count times 64 bytes
  sum_read_setup_a: assert property (@(posedge clock) disable iff (!rst_b)
    state == STRC_DISPATCH && !key_bad && op == `STRC_OP_CHECKSUM |=> flash_re && flash_addr == '0
    && total == ((select == 8'h00) ? {`STRC_FULL_BLOCKS, 6'h00} : {1'b0, select, 6'h00}))
    else $error("checksum read setup wrong");
  // Reads never pass the summed range of the bank
  sum_bank_range_a: assert property (@(posedge clock) disable iff (!rst_b)
    flash_re |-> 15'(flash_addr) < total)
    else $error("checksum read outside summed range");
  // One read in flight at a time
  sum_read_gap_a: assert property (@(posedge clock) disable iff (!rst_b)
    flash_re |=> !flash_re)
    else $error("checksum reads must not be back to back");
  // Each arriving byte adds to the low byte with carry into the high byte
  sum_byte_add_a: assert property (@(posedge clock) disable iff (!rst_b)
    state == STRC_SUM && pend |=> sum == $past(sum) + {8'h00, $past(flash_rdata)})
    else $error("checksum byte add wrong");
  // Low checksum byte lands at the first key byte
  sum_low_store_a: assert property (@(posedge clock) disable iff (!rst_b)
    state == STRC_FINISH && op == `STRC_OP_CHECKSUM && !key_bad && count == 15'h0000
    |=> sram_wr.we && sram_wr.addr == `STRC_ADDR_SUP_KEY && sram_wr.data == $past(sum[7:0]))
    else $error("checksum low byte store wrong");
  // Table one returns the revision counter in A
  table_one_acc_a: assert property (@(posedge clock) disable iff (!rst_b)
    result.done && !result.key_error && op == `STRC_OP_TABLE && select[2:0] == 3'h1 |-> result.acc == INT_REV_COUNT)
    else $error("table 1 must return the revision counter");
  // Fifth table byte is the first trim slot
  trim_slot_a: assert property (@(posedge clock) disable iff (!rst_b)
    state == STRC_TABLE && count[2:0] == 3'h4
    |=> sram_wr.we && sram_wr.addr == `STRC_ADDR_TRIM0 && sram_wr.data == ROW_IMAGE[{select[2:0], 6'h20} +: 8])
    else $error("trim byte not at FCh");
  // Key pointer comes up on the call
  call_key_addr_a: assert property (@(posedge clock) disable iff (!rst_b)
    state == STRC_IDLE && call.start |=> busy && sram_raddr == `STRC_ADDR_SUP_KEY)
    else $error("call must read the key byte first");
endmodule : strc_service

// [tb/strc_cpu_model.sv]
`timescale 1ns/1ns
// Firmware side of the service block: parameter SRAM and flash array
module strc_cpu_model (
  input  wire logic                       clock,
  input  wire logic                       rst_b,
  input  wire logic                       load,
  input  wire logic [7:0]                 key,
  input  wire logic [7:0]                 sel,
  input  wire logic [7:0]                 sram_raddr,
  input  wire strc_pkg::strc_sram_wr_type sram_wr,
  input  wire logic                       flash_re,
  input  wire logic [13:0]                flash_addr,
  output logic [7:0]                      sram_rdata,
  output logic [7:0]                      flash_rdata
);
  import strc_pkg::*;
  logic [7:0] mem [0:255];
  // Firmware fills the parameter block before the call, the block writes results back
  always @(posedge clock) begin
    if (load) begin
      mem[8'hF8] <= key;
      mem[8'hF9] <= 8'hE3; // Stack frame value
      mem[8'hFA] <= sel;
    end else if (sram_wr.we) begin
      mem[sram_wr.addr] <= sram_wr.data;
    end
    sram_rdata <= mem[sram_raddr];
  end
  // Flash answers one cycle after a strobe, then scrambles so stale data never looks valid
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      flash_rdata <= 8'h00;
    end else if (flash_re) begin
      flash_rdata <= flash_addr[7:0] ^ {flash_addr[13:8], 2'b01};
    end else begin
      flash_rdata <= ~flash_rdata;
    end
  end
endmodule : strc_cpu_model

// [tb/testbench.sv]
`timescale 1ns/1ns
module testbench;
  import strc_pkg::*;
  localparam logic [15:0] DIE_REV = 16'h5A3C; // Arbitrary value
  localparam logic [7:0]  FAMILY  = 8'h21;    // Arbitrary value
  // Distinct byte in every row position so a wrong table or order shows
  function automatic logic [511:0] make_row();
    logic [511:0] r;
    for (int i = 0; i < 64; i++) begin
      r[i*8+:8] = 8'(i * 37 + 19);
    end
    return r;
  endfunction : make_row
  localparam logic [511:0] ROW = make_row();
  logic             clock;
  logic             rst_b;
  strc_call_type    call;
  strc_result_type  result;
  strc_sram_wr_type sram_wr;
  logic [7:0]       sram_raddr;
  logic [7:0]       sram_rdata;
  logic [7:0]       flash_rdata;
  logic [7:0]       key;
  logic [7:0]       sel;
  logic [7:0]       seed;
  logic [13:0]      flash_addr;
  logic             flash_re;
  logic             busy;
  logic             load;
  int               failures;
  int               samples_checked;
  int               wr_count;
  int               rd_count;
  int               cycles;
  strc_service #(.DIE_REVISION(DIE_REV), .FAMILY_ID(FAMILY), .ROW_IMAGE(ROW), .FLASH_AW(14)) DUT (
    .clock(clock), .rst_b(rst_b), .call(call), .sram_rdata(sram_rdata), .flash_rdata(flash_rdata),
    .result(result), .sram_raddr(sram_raddr), .sram_wr(sram_wr), .flash_re(flash_re),
    .flash_addr(flash_addr), .busy(busy));
  strc_cpu_model model (
    .clock(clock), .rst_b(rst_b), .load(load), .key(key), .sel(sel), .sram_raddr(sram_raddr),
    .sram_wr(sram_wr), .flash_re(flash_re), .flash_addr(flash_addr), .sram_rdata(sram_rdata),
    .flash_rdata(flash_rdata));
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr
  // Reference checksum over the model's flash pattern, carry folded into the high byte
  function automatic logic [15:0] exp_sum(input int blocks);
    logic [7:0] lo;
    logic [7:0] hi;
    logic [7:0] b;
    logic       c;
    lo = 8'h00;
    hi = 8'h00;
    for (int i = 0; i < blocks * 64; i++) begin
      b = 8'(i) ^ {6'(i >> 8), 2'b01};
      {c, lo} = lo + b;
      hi = hi + 8'(c);
    end
    return {hi, lo};
  endfunction : exp_sum
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // Hang guard and port monitor; flash must be read in order from address zero
  always @(posedge clock) begin
    cycles++;
    if (cycles == 50000) begin
      failures++;
      report_and_stop();
    end
    if (sram_wr.we === 1'b1) begin
      wr_count++;
    end
    if (flash_re === 1'b1) begin
      chk("flash_addr", 16'(rd_count), {2'b00, flash_addr});
      rd_count++;
    end
  end
  // Parameter load, one start pulse, bounded wait for done
  task automatic run_call(input logic [7:0] op, input logic [7:0] k, input logic [7:0] s);
    int n;
    key = k;
    sel = s;
    load = 1'b1;
    @(posedge clock);
    #2;
    load = 1'b0;
    wr_count = 0;
    rd_count = 0;
    call = '{start: 1'b1, op: op};
    @(posedge clock);
    #2;
    call.start = 1'b0;
    chk("busy", 16'h0001, {15'h0, busy});
    n = 0;
    while (result.done !== 1'b1 && n < 40000) begin
      @(posedge clock);
      #2;
      n++;
    end
    chk("done", 16'h0001, {15'h0, result.done});
  endtask : run_call
  task automatic table_case(input logic [2:0] t);
    logic [15:0] ax;
    seed = lfsr(seed);
    run_call(8'h06, 8'h3A, {seed[7:3], t});
    ax = (t == 0) ? {DIE_REV[7:0], FAMILY} : (t == 1) ? 16'h00FF : 16'hFFFF;
    chk("acc_idx", ax, {result.acc, result.idx});
    chk("write_count", 16'h0008, wr_count[15:0]);
    for (int k = 0; k < 8; k++) begin
      chk("table_byte", {8'h0, ROW[int'(t)*64+k*8+:8]}, {8'h0, model.mem[8'hF8+k]});
    end
  endtask : table_case
  task automatic sum_case(input logic [7:0] cnt);
    int blocks;
    blocks = (cnt == 8'h00) ? 256 : int'(cnt);
    run_call(8'h07, 8'h3A, cnt);
    // High byte is written with done and lands in the model one edge later
    @(posedge clock);
    #2;
    chk("sum_reads", 16'(blocks * 64), rd_count[15:0]);
    chk("sum", exp_sum(blocks), {model.mem[8'hF9], model.mem[8'hF8]});
  endtask : sum_case
  initial begin
    rst_b = 1'b0;
    call = '0;
    load = 1'b0;
    key = 8'h00;
    sel = 8'h00;
    failures = 0;
    samples_checked = 0;
    wr_count = 0;
    rd_count = 0;
    cycles = 0;
    seed = 8'h2F;
    repeat (5) @(posedge clock);
    #2;
    rst_b = 1'b1;
    for (int t = 0; t < 8; t++) begin
      table_case(3'(t));
    end
    // Wrong key: refused with flag, blank returns and no parameter writes
    run_call(8'h06, 8'h3B, 8'h02);
    chk("key_error", 16'h0001, {15'h0, result.key_error});
    chk("bad_acc_idx", 16'hFFFF, {result.acc, result.idx});
    chk("bad_writes", 16'h0000, wr_count[15:0]);
    // Unknown operation code: blank returns, no writes, no key error
    run_call(8'h05, 8'h3A, 8'h00);
    chk("op_acc_idx", 16'hFFFF, {result.acc, result.idx});
    chk("op_error", 16'h0000, {15'h0, result.key_error});
    chk("op_writes", 16'h0000, wr_count[15:0]);
    // Repeat of the one-block sum shows the accumulator restarts from zero
    sum_case(8'h01);
    sum_case(8'h01);
    seed = lfsr(seed);
    sum_case({5'h00, seed[2:0]} + 8'h01);
    sum_case(8'h00);
    report_and_stop();
  end
endmodule : testbench
